// File: inc/ssp_defines.svh
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH
`define SSP_MAX_BITS 16
`define SSP_MIN_BITS 4
`define SSP_WORD_RST 16'h0000
`define SSP_SYNC_IDLE_HIGH 3'h7
`endif

// File: inc/ssp_pkg.sv
`include "ssp_defines.svh"
package ssp_pkg;
   typedef enum logic {FMT_PULSE, FMT_SPI} frame_fmt_e;
   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_GAP} run_state_e;
   typedef struct packed {
      logic enable;
      logic master;
      frame_fmt_e fmt;
      logic clock_polarity_bit;
      logic clock_phase_bit;
      logic [3:0] size_m1;
      logic [7:0] prescale_divisor;
      logic [7:0] rate_factor;
   } port_cfg_s;
   typedef struct packed {
      logic serial_bit_clock;
      logic frame_select;
      logic serial_rx_line;
   } pin_in_s;
   typedef struct packed {
      logic serial_bit_clock;
      logic serial_bit_clock_oe_n;
      logic frame_select;
      logic frame_select_oe_n;
      logic serial_tx_line;
      logic serial_tx_line_oe_n;
   } pin_out_s;
   typedef struct packed {
      run_state_e mode;
      logic [5:0] step;
      logic [6:0] pre_cnt;
      logic [7:0] rate_cnt;
      logic [`SSP_MAX_BITS-1:0] tx_shift;
      logic [`SSP_MAX_BITS-1:0] hold;
      logic [`SSP_MAX_BITS-1:0] rx_shift;
      logic [3:0] idx;
      logic [3:0] bits;
      logic cont;
      logic armed;
      logic [2:0] clk_s;
      logic [2:0] fss_s;
      logic [2:0] rx_s;
      logic clk_f;
      logic fss_f;
      logic rx_f;
      logic tx_pop;
      logic rx_valid;
      logic [`SSP_MAX_BITS-1:0] rx_data;
      logic busy;
      pin_out_s po;
   } port_state_s;
endpackage

// File: rtl/sync_serial_frame_formats.sv
// Operation
// - pulse format idle: clock and frame select low, transmit line released
// - pulse format: word present gives one-period frame pulse and loads shifter
// - pulse format: msb leaves on rising edge after pulse, word 4 to 16 bits
// - pulse format: both ends sample incoming bits on falling clock edges
// - pulse format: received word pushed at first rising edge after lsb
// - spi format: four wires, low frame select qualifies the transfer
// - spi format: idle clock level equals polarity bit
// - spi format: phase 0 captures on first edge, phase 1 on second
// - spi idle: select high, transmit low, clock driver on only as master
// - spi master start: select low and transmit driver on when word waits
// - mode 0: data half period after select falls, clock half later
// - spi: select returns high one bit period after last capture
// - phase 0: select pulses high between back-to-back words
// - polarity 0 phase 1: data and first rising edge half after select
// - phase 1: select stays low between back-to-back words
// - polarity 1 phase 0: slave drives at select fall, master half later
// - polarity 1 phase 1: data and first falling edge half after select
// - bit clock is system clock over even prescale times rate plus one
// - words go msb first, length 4 to 16 bits
`timescale 1ns/1ps
`default_nettype none
module sync_serial_frame_formats
   import ssp_pkg::*;
#(
   parameter int MAX_BITS = `SSP_MAX_BITS
) (
   input wire logic clk,
   input wire logic nrst,
   input wire port_cfg_s cfg,
   input wire logic tx_valid,
   input wire logic [15:0] tx_data,
   output logic tx_pop,
   output logic rx_valid,
   output logic [15:0] rx_data,
   output logic busy,
   input wire pin_in_s pin_in,
   output var pin_out_s pin_out
);
   if (MAX_BITS < `SSP_MIN_BITS || MAX_BITS > `SSP_MAX_BITS) begin : g_bad_width
      $error("MAX_BITS outside 4..16");
   end

   port_state_s st;
   port_state_s nx;
   logic [1:0] rst_pipe;
   logic rst_n;
   logic [6:0] pre_end;
   logic tick;
   logic spi;
   logic [3:0] last;
   logic [5:0] n2;

   // word length is clamped so a bad size never selects a missing bit
   function automatic logic [3:0] last_idx(input logic [3:0] s);
      logic [3:0] r;
      r = s;
      if (s < 4'(`SSP_MIN_BITS - 1)) r = 4'(`SSP_MIN_BITS - 1);
      if (s > 4'(MAX_BITS - 1)) r = 4'(MAX_BITS - 1);
      return r;
   endfunction

   function automatic logic [15:0] keep_low(input logic [15:0] w, input logic [3:0] l);
      logic [15:0] m;
      m = 16'hFFFF >> (4'hF - l);
      return w & m;
   endfunction

   function automatic logic [15:0] shift_in(input logic [15:0] w, input logic b);
      return {w[14:0], b};
   endfunction

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   // half bit period = prescale/2 * (1 + rate)
   assign pre_end = (cfg.prescale_divisor[7:1] == 7'h00) ? 7'h00 :
                    cfg.prescale_divisor[7:1] - 7'h01;
   assign tick = (st.pre_cnt == pre_end) && (st.rate_cnt == cfg.rate_factor);
   assign spi = (cfg.fmt == FMT_SPI);
   assign last = last_idx(cfg.size_m1);
   assign n2 = {1'b0, last, 1'b0} + 6'h02;

   always_comb begin
      logic [5:0] s;
      logic go;
      logic push;
      logic rise;
      logic fall;
      logic lead;
      logic trail;
      logic ld;
      logic cap;
      logic drv;
      logic [15:0] w;
      logic [3:0] i;
      s = st.step;
      go = 1'b0;
      push = 1'b0;
      w = st.tx_shift;
      i = st.idx;
      nx = st;
      nx.tx_pop = 1'b0;
      nx.rx_valid = 1'b0;
      // second and third stage must agree before a pin change counts
      nx.clk_s = {st.clk_s[1:0], pin_in.serial_bit_clock};
      nx.fss_s = {st.fss_s[1:0], pin_in.frame_select};
      nx.rx_s = {st.rx_s[1:0], pin_in.serial_rx_line};
      if (st.clk_s[1] == st.clk_s[2]) nx.clk_f = st.clk_s[2];
      if (st.fss_s[1] == st.fss_s[2]) nx.fss_f = st.fss_s[2];
      if (st.rx_s[1] == st.rx_s[2]) nx.rx_f = st.rx_s[2];
      rise = nx.clk_f & ~st.clk_f;
      fall = ~nx.clk_f & st.clk_f;
      lead = cfg.clock_polarity_bit ? fall : rise;
      trail = cfg.clock_polarity_bit ? rise : fall;
      ld = 1'b0;
      cap = 1'b0;
      drv = 1'b0;
      if (st.mode == ST_IDLE) begin
         nx.pre_cnt = 7'h00;
         nx.rate_cnt = 8'h00;
      end else if (tick) begin
         nx.pre_cnt = 7'h00;
         nx.rate_cnt = 8'h00;
         s = st.step + 6'h01;
      end else if (st.pre_cnt == pre_end) begin
         nx.pre_cnt = 7'h00;
         nx.rate_cnt = st.rate_cnt + 8'h01;
      end else begin
         nx.pre_cnt = st.pre_cnt + 7'h01;
      end
      if (!cfg.enable || !cfg.master) begin
         nx.mode = ST_IDLE;
      end
      if (!cfg.enable) begin
         nx.cont = 1'b0;
         nx.armed = 1'b0;
         nx.bits = 4'h0;
         nx.po.serial_bit_clock = spi & cfg.clock_polarity_bit;
         nx.po.serial_bit_clock_oe_n = ~cfg.master;
         nx.po.frame_select = spi;
         nx.po.frame_select_oe_n = ~cfg.master;
         nx.po.serial_tx_line = 1'b0;
         nx.po.serial_tx_line_oe_n = 1'b1;
      end else if (cfg.master) begin
         case (st.mode)
            ST_IDLE: begin
               nx.po.serial_bit_clock = spi & cfg.clock_polarity_bit;
               nx.po.serial_bit_clock_oe_n = 1'b0;
               nx.po.frame_select = spi;
               nx.po.frame_select_oe_n = 1'b0;
               nx.po.serial_tx_line = 1'b0;
               nx.po.serial_tx_line_oe_n = 1'b1;
               go = tx_valid;
            end
            ST_GAP: go = tick;
            ST_RUN: begin
               if (tick && !spi) begin
                  push = (s == n2 + 6'h02);
                  if (push && st.cont) begin
                     s = 6'h02;
                     w = st.hold;
                     i = last;
                     nx.tx_shift = st.hold;
                     nx.cont = 1'b0;
                  end
                  nx.po.serial_bit_clock = ~s[0];
                  // filtered value of this cycle: a bit changed one half earlier is seen
                  if (s[0] && s >= 6'h03 && s <= n2 + 6'h01) begin
                     nx.rx_shift = shift_in(st.rx_shift, nx.rx_f);
                  end
                  if (!s[0] && s >= 6'h02 && s <= n2) begin
                     nx.po.serial_tx_line = w[i];
                     nx.po.serial_tx_line_oe_n = 1'b0;
                     nx.idx = i - 4'h1;
                  end
                  if (s == 6'h02) nx.po.frame_select = 1'b0;
                  if (s == n2 && tx_valid) begin
                     nx.po.frame_select = 1'b1;
                     nx.hold = tx_data;
                     nx.tx_pop = 1'b1;
                     nx.cont = 1'b1;
                  end
                  if (push) begin
                     nx.rx_valid = 1'b1;
                     nx.rx_data = keep_low(st.rx_shift, last);
                  end
                  if (s == n2 + 6'h03) begin
                     nx.po.serial_tx_line = 1'b0;
                     nx.po.serial_tx_line_oe_n = 1'b1;
                     nx.mode = ST_IDLE;
                  end
               end else if (tick) begin
                  // odd steps change data, even steps capture
                  if (s[0] && s <= n2 - 6'h01) begin
                     nx.po.serial_tx_line = st.tx_shift[st.idx];
                     nx.idx = st.idx - 4'h1;
                     if (cfg.clock_phase_bit || s >= 6'h03) begin
                        nx.po.serial_bit_clock = ~st.po.serial_bit_clock;
                     end
                  end
                  if (!s[0] && s <= n2) begin
                     nx.rx_shift = shift_in(st.rx_shift, nx.rx_f);
                     nx.po.serial_bit_clock = ~st.po.serial_bit_clock;
                  end
                  if (s == n2) begin
                     nx.rx_valid = 1'b1;
                     nx.rx_data = keep_low(shift_in(st.rx_shift, nx.rx_f), last);
                     if (cfg.clock_phase_bit && tx_valid) begin
                        s = 6'h00;
                        nx.tx_shift = tx_data;
                        nx.idx = last;
                        nx.tx_pop = 1'b1;
                     end
                  end
                  if (s == n2 + 6'h01 && !cfg.clock_phase_bit) begin
                     nx.po.serial_bit_clock = ~st.po.serial_bit_clock;
                  end
                  if (s == n2 + 6'h02) begin
                     nx.po.frame_select = 1'b1;
                     nx.po.serial_tx_line = 1'b0;
                     nx.po.serial_tx_line_oe_n = 1'b1;
                     nx.mode = (!cfg.clock_phase_bit && tx_valid) ? ST_GAP : ST_IDLE;
                  end
               end
            end
            default: nx.mode = ST_IDLE;
         endcase
         nx.step = s;
         if (go) begin
            nx.mode = ST_RUN;
            nx.step = 6'h00;
            nx.tx_shift = tx_data;
            nx.idx = last;
            nx.tx_pop = 1'b1;
            nx.cont = 1'b0;
            nx.po.frame_select = ~spi;
            nx.po.serial_tx_line_oe_n = ~spi;
            nx.po.serial_tx_line = 1'b0;
            if (!spi) nx.po.serial_bit_clock = 1'b1;
         end
      end else begin
         nx.po.serial_bit_clock_oe_n = 1'b1;
         nx.po.frame_select_oe_n = 1'b1;
         // an empty fifo sends zeros when the far master clocks a word
         w = tx_valid ? tx_data : 16'h0000;
         if (spi && nx.fss_f) begin
            nx.po.serial_tx_line = 1'b0;
            nx.po.serial_tx_line_oe_n = 1'b1;
            nx.armed = 1'b0;
            nx.bits = 4'h0;
         end else if (spi) begin
            nx.po.serial_tx_line_oe_n = 1'b0;
            ld = cfg.clock_phase_bit ? (lead & ~st.armed) : st.fss_f;
            cap = (cfg.clock_phase_bit ? trail : lead) & st.armed;
            drv = (cfg.clock_phase_bit ? lead : trail) & st.armed;
         end else if (rise) begin
            if (st.cont) begin
               nx.rx_valid = 1'b1;
               nx.rx_data = keep_low(st.rx_shift, last);
               nx.cont = 1'b0;
            end
            ld = nx.fss_f;
            drv = ~nx.fss_f & st.armed;
            if (!nx.fss_f && !st.armed) nx.po.serial_tx_line_oe_n = 1'b1;
            if (drv) nx.po.serial_tx_line_oe_n = 1'b0;
         end else begin
            cap = fall & st.armed;
         end
         if (ld) begin
            nx.tx_shift = w;
            nx.tx_pop = tx_valid;
            nx.armed = 1'b1;
            nx.bits = 4'h0;
            nx.idx = spi ? last - 4'h1 : last;
            if (spi) nx.po.serial_tx_line = w[last];
         end else if (drv) begin
            nx.po.serial_tx_line = st.tx_shift[st.idx];
            nx.idx = st.idx - 4'h1;
         end
         if (cap) begin
            nx.rx_shift = shift_in(st.rx_shift, st.rx_f);
            nx.bits = st.bits + 4'h1;
            if (st.bits == last) begin
               nx.armed = 1'b0;
               if (spi) begin
                  nx.rx_valid = 1'b1;
                  nx.rx_data = keep_low(shift_in(st.rx_shift, st.rx_f), last);
               end else begin
                  nx.cont = 1'b1;
               end
            end
         end
      end
      nx.busy = cfg.master ? (nx.mode != ST_IDLE) : ~nx.fss_f ^ ~spi;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
         st.fss_s <= `SSP_SYNC_IDLE_HIGH;
         st.fss_f <= 1'b1;
         st.po.serial_bit_clock_oe_n <= 1'b1;
         st.po.frame_select_oe_n <= 1'b1;
         st.po.serial_tx_line_oe_n <= 1'b1;
      end else begin
         st <= nx;
      end
   end

   assign tx_pop = st.tx_pop;
   assign rx_valid = st.rx_valid;
   assign rx_data = st.rx_data;
   assign busy = st.busy;
   assign pin_out = st.po;

   logic m_ti;
   logic m_spi;
   logic [15:0] gap;
   logic [15:0] half_m1;
   assign m_ti = cfg.enable && cfg.master && !spi;
   assign m_spi = cfg.enable && cfg.master && spi;
   assign half_m1 = 16'(16'(cfg.prescale_divisor[7:1]) * 16'({1'b0, cfg.rate_factor} + 9'h001)
                    - 16'h0001);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gap <= 16'h0000;
      end else begin
         gap <= (tick || st.mode == ST_IDLE) ? 16'h0000 : gap + 16'h0001;
      end
   end

   property p_ti_idle;
      @(posedge clk) disable iff (!rst_n)
      m_ti && st.mode == ST_IDLE && $past(st.mode) == ST_IDLE && $stable(cfg)
      |-> !pin_out.serial_bit_clock && !pin_out.frame_select && pin_out.serial_tx_line_oe_n;
   endproperty
   a_ti_idle: assert property (p_ti_idle) else $error("pulse idle pins wrong");

   property p_ti_pulse;
      @(posedge clk) disable iff (!rst_n)
      m_ti && $rose(pin_out.frame_select) |-> tx_pop;
   endproperty
   a_ti_pulse: assert property (p_ti_pulse) else $error("frame pulse without load");

   property p_ti_msb;
      @(posedge clk) disable iff (!rst_n)
      m_ti && $fell(pin_out.frame_select) && st.mode == ST_RUN
      |-> !pin_out.serial_tx_line_oe_n && $rose(pin_out.serial_bit_clock);
   endproperty
   a_ti_msb: assert property (p_ti_msb) else $error("msb not on rising edge");

   property p_ti_push;
      @(posedge clk) disable iff (!rst_n)
      m_ti && rx_valid |-> $rose(pin_out.serial_bit_clock);
   endproperty
   a_ti_push: assert property (p_ti_push) else $error("rx push off rising edge");

   property p_spi_idle;
      @(posedge clk) disable iff (!rst_n)
      m_spi && st.mode == ST_IDLE && $past(st.mode) == ST_IDLE && $stable(cfg)
      |-> pin_out.serial_bit_clock == cfg.clock_polarity_bit && pin_out.frame_select
          && !pin_out.serial_tx_line && !pin_out.serial_bit_clock_oe_n;
   endproperty
   a_spi_idle: assert property (p_spi_idle) else $error("spi idle pins wrong");

   property p_spi_start;
      @(posedge clk) disable iff (!rst_n)
      m_spi && $fell(pin_out.frame_select) |-> !pin_out.serial_tx_line_oe_n && tx_pop
         && pin_out.serial_bit_clock == cfg.clock_polarity_bit;
   endproperty
   a_spi_start: assert property (p_spi_start) else $error("bad spi start");

   property p_spi_sep;
      @(posedge clk) disable iff (!rst_n)
      m_spi && !cfg.clock_phase_bit && tx_pop |-> $past(pin_out.frame_select);
   endproperty
   a_spi_sep: assert property (p_spi_sep) else $error("no select pulse between words");

   property p_spi_hold;
      @(posedge clk) disable iff (!rst_n)
      m_spi && cfg.clock_phase_bit && tx_pop && !pin_out.frame_select
      |=> !pin_out.frame_select [*2];
   endproperty
   a_spi_hold: assert property (p_spi_hold) else $error("select rose in burst");

   property p_half;
      @(posedge clk) disable iff (!rst_n)
      tick && st.mode != ST_IDLE && cfg.prescale_divisor >= 8'h02 && $stable(cfg)
      |-> gap == half_m1;
   endproperty
   a_half: assert property (p_half) else $error("half period length wrong");

   property p_slave_sel;
      @(posedge clk) disable iff (!rst_n)
      cfg.enable && !cfg.master && spi && $stable(cfg) && $past(cfg.enable) && st.fss_f
      |-> pin_out.serial_tx_line_oe_n && pin_out.serial_bit_clock_oe_n;
   endproperty
   a_slave_sel: assert property (p_slave_sel) else $error("slave drove while deselected");

   c_ti_word: cover property (@(posedge clk) disable iff (!rst_n) m_ti && rx_valid);
   c_spi_burst: cover property (@(posedge clk) disable iff (!rst_n)
      m_spi && cfg.clock_phase_bit && tx_pop && !pin_out.frame_select);
   c_slave_word: cover property (@(posedge clk) disable iff (!rst_n)
      cfg.enable && !cfg.master && rx_valid);
endmodule // sync_serial_frame_formats
`default_nettype wire

// File: sim/serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
   input wire logic sck,
   input wire logic fss,
   input wire logic tx,
   input wire logic spi,
   input wire logic cpol,
   input wire logic cpha,
   input wire logic [4:0] n,
   input wire logic [15:0] word,
   output logic rx,
   output logic [15:0] got,
   output logic [7:0] n_got
);
   int k = 0;
   int c = 0;
   logic armed = 1'b0;
   logic last = 1'b0;
   logic [15:0] sh = 16'h0000;
   initial begin
      rx = 1'b1;
      got = 16'h0000;
      n_got = 8'h00;
   end
   task automatic put(input int i);
      rx = word[i];
      last = word[i];
   endtask
   task automatic take();
      sh = {sh[14:0], tx};
      c++;
      if (c == n) begin
         got = sh;
         n_got++;
         c = 0;
         sh = 16'h0000;
         armed = 1'b0;
      end
   endtask
   // select low qualifies the frame; phase 0 shows the msb at once
   always @(negedge fss) if (spi) begin
      c = 0;
      sh = 16'h0000;
      k = cpha ? n : n - 1;
      if (!cpha) put(k);
   end
   // a released line never keeps the last bit, so a late sample is caught
   always @(posedge fss) if (spi) rx = ~last;
   always @(sck) if (spi && fss === 1'b0) begin
      if (sck === !(cpol ^ cpha)) take();
      else begin
         k = (k == 0) ? n - 1 : k - 1;
         put(k);
      end
   end
   // pulse format: the select pulse seen at a falling edge arms the frame
   always @(negedge sck) if (!spi) begin
      if (fss === 1'b1) begin
         armed = 1'b1;
         k = n;
         c = 0;
         sh = 16'h0000;
      end else if (armed) begin
         take();
         if (!armed) rx = ~last;
      end
   end
   always @(posedge sck) if (!spi && armed && k > 0) begin
      k--;
      put(k);
   end
endmodule // serial_peer
`default_nettype wire

// File: sim/sync_serial_frame_formats_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end
`define WAIT_FOR(c) begin w = 0; while ((c) !== 1'b1) begin @(negedge clk); w++; \
   if (w > 4000) begin n_mismatch++; results(); end end end
module sync_serial_frame_formats_test import ssp_pkg::*;;
   typedef struct packed {
      logic spi; logic cpol; logic cpha; logic [3:0] sm1;
      logic [7:0] pre; logic [7:0] rate; logic [15:0] tw; logic [15:0] pw;
   } row_s;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   port_cfg_s cfg;
   logic tx_valid, tx_pop, rx_valid, busy, prx;
   logic [15:0] tx_data, rx_data, got, pw, m;
   logic [7:0] n_got;
   pin_in_s pin_in;
   pin_out_s pin_out;
   logic sck_q, fss_q;
   int n_mismatch = 0;
   int compares = 0;
   int w, g0, r0, hcnt, half_seen, fcnt, fss_len;
   int n_rise = 0;
   row_s rows[6];
   always #4 clk = ~clk;
   // master pads loop back; released pads fall to their idle levels
   assign pin_in = '{pin_out.serial_bit_clock_oe_n ? cfg.clock_polarity_bit
      : pin_out.serial_bit_clock, pin_out.frame_select_oe_n | pin_out.frame_select, prx};
   sync_serial_frame_formats dut (.clk(clk), .nrst(nrst), .cfg(cfg), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_pop(tx_pop), .rx_valid(rx_valid), .rx_data(rx_data),
      .busy(busy), .pin_in(pin_in), .pin_out(pin_out));
   serial_peer peer (.sck(pin_out.serial_bit_clock), .fss(pin_out.frame_select),
      .tx(pin_out.serial_tx_line), .spi(cfg.fmt == FMT_SPI), .cpol(cfg.clock_polarity_bit),
      .cpha(cfg.clock_phase_bit), .n(5'(cfg.size_m1) + 5'd1), .word(pw), .rx(prx),
      .got(got), .n_got(n_got));
   always @(posedge clk) begin
      sck_q <= pin_out.serial_bit_clock;
      fss_q <= pin_out.frame_select;
      hcnt <= (pin_out.serial_bit_clock !== sck_q) ? 1 : hcnt + 1;
      if (pin_out.serial_bit_clock !== sck_q) half_seen <= hcnt;
      fcnt <= pin_out.frame_select ? fcnt + 1 : 0;
      if (!pin_out.frame_select && fss_q) fss_len <= fcnt;
      if (pin_out.frame_select && !fss_q) n_rise <= n_rise + 1;
   end
   task automatic results();
      if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // config only changes while the port is off
   task automatic setup(input row_s r, input logic mst);
      @(negedge clk);
      cfg.enable = 1'b0;
      @(negedge clk);
      cfg = '{1'b1, mst, frame_fmt_e'(r.spi), r.cpol, r.cpha, r.sm1, r.pre, r.rate};
      pw = r.pw;
      repeat (3) @(negedge clk);
   endtask
   task automatic send(input logic [15:0] a, input logic [15:0] b, input int nw);
      tx_data = a;
      tx_valid = 1'b1;
      `WAIT_FOR(tx_pop)
      tx_data = b;
      if (nw == 1) tx_valid = 1'b0;
      else begin
         @(negedge clk);
         `WAIT_FOR(tx_pop)
         tx_valid = 1'b0;
      end
   endtask
   initial begin
      cfg = '0;
      tx_valid = 1'b0;
      tx_data = 16'h0000;
      pw = 16'h0000;
      rows = '{
         '{1'b1, 1'b0, 1'b0, 4'h7, 8'h02, 8'h03, 16'ha5c3, 16'h3c5a},
         '{1'b1, 1'b0, 1'b1, 4'hf, 8'h04, 8'h01, 16'h8001, 16'h7ffe},
         '{1'b1, 1'b1, 1'b0, 4'h3, 8'h02, 8'h03, 16'h000b, 16'h0006},
         '{1'b1, 1'b1, 1'b1, 4'hb, 8'h08, 8'h01, 16'h0f3c, 16'h0c96},
         '{1'b0, 1'b0, 1'b0, 4'hf, 8'h02, 8'h03, 16'hc0de, 16'h1234},
         '{1'b0, 1'b0, 1'b0, 4'h3, 8'h0a, 8'h00, 16'h0009, 16'h0005}};
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      foreach (rows[i]) begin
         m = 16'hffff >> (15 - rows[i].sm1);
         g0 = n_got;
         setup(rows[i], 1'b1);
         send(rows[i].tw, 16'h0000, 1);
         `WAIT_FOR(rx_valid)
         `CHK("rx_data", rows[i].pw & m, rx_data)
         `WAIT_FOR(!busy)
         repeat (4) @(negedge clk);
         `CHK("peer word", rows[i].tw & m, got)
         `CHK("peer count", 8'(g0 + 1), n_got)
         `CHK("half period", (int'(rows[i].pre) * (1 + int'(rows[i].rate))) / 2, half_seen)
         if (rows[i].spi) begin
            `CHK("idle clock", rows[i].cpol, pin_out.serial_bit_clock)
            `CHK("idle select tx", 2'b10, {pin_out.frame_select, pin_out.serial_tx_line})
            `CHK("clock pad", 1'b0, pin_out.serial_bit_clock_oe_n)
         end else begin
            `CHK("pulse width", int'(rows[i].pre) * (1 + int'(rows[i].rate)), fss_len)
            `CHK("idle pins", 2'b00, {pin_out.serial_bit_clock, pin_out.frame_select})
            `CHK("tx released", 1'b1, pin_out.serial_tx_line_oe_n)
         end
      end
      // two words back to back: phase 0 lifts select between them, phase 1 does not
      for (int p = 0; p < 2; p++) begin
         setup(row_s'{1'b1, 1'b0, p[0], 4'h7, 8'h02, 8'h03, 16'h0000, 16'h0081}, 1'b1);
         g0 = n_got;
         r0 = n_rise;
         send(16'h005a, 16'h00c3, 2);
         `WAIT_FOR(n_got == 8'(g0 + 2))
         `WAIT_FOR(!busy)
         repeat (4) @(negedge clk);
         `CHK("burst last word", 16'h00c3, got)
         `CHK("select rises", (p == 0) ? 2 : 1, n_rise - r0)
      end
      setup(rows[0], 1'b0);
      `CHK("slave clock pad", 1'b1, pin_out.serial_bit_clock_oe_n)
      // mid-run reset: every pad released, pulses quiet
      @(negedge clk);
      nrst = 1'b0;
      @(negedge clk);
      `CHK("reset pads", 6'b010101, pin_out)
      `CHK("reset pulses", 3'b000, {tx_pop, rx_valid, busy})
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      `CHK("slave tx released", 1'b1, pin_out.serial_tx_line_oe_n)
      results();
   end
endmodule // sync_serial_frame_formats_test
`default_nettype wire
